/* File: hw/radio_irq_pkg.sv */
package radio_irq_pkg;

	// Avalon byte address width; each register holds one aligned word.
	localparam int unsigned ADDR_W = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] MASK_IDX = 8'h91;
	localparam logic [7:0] FLAGS_IDX = 8'hE9;
	localparam logic [7:0] CTRL_IDX = 8'hA0;

	// Values after reset.
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [31:0] READ_RST = 32'h0000_0000;

	// Event flag and mask bit positions.
	localparam int unsigned TX_SHORT_BIT = 7;
	localparam int unsigned RX_OVERRUN_BIT = 6;
	localparam int unsigned RX_WAIT_EXPIRED_BIT = 5;
	localparam int unsigned PACKET_FINISHED_BIT = 4;
	localparam int unsigned CARRIER_DETECT_BIT = 3;
	localparam int unsigned PREAMBLE_QUALITY_BIT = 2;
	localparam int unsigned CHANNEL_CLEAR_BIT = 1;
	localparam int unsigned SYNC_FOUND_BIT = 0;

	// Control register bit positions.
	localparam int unsigned CTRL_BT_FLAG = 0;
	localparam int unsigned CTRL_GR_FLAG = 1;
	localparam int unsigned CTRL_BT_EN = 2;
	localparam int unsigned CTRL_GR_EN = 3;
	localparam int unsigned CTRL_APPEND = 4;
	localparam int unsigned CTRL_OVERRUN = 5;
	localparam int unsigned CTRL_SHORT = 6;
	localparam int unsigned CTRL_TX = 7;

	// Command strobe codes.
	localparam logic [7:0] TX_STROBE_CODE = 8'h03;
	localparam logic [7:0] IDLE_STROBE_CODE = 8'h04;

	// Radio data path states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TX = 3'b010,
		ST_STUCK = 3'b100
	} radio_state_t;

	// True when a byte address selects the register with the given index.
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		reg_hit = (addr[ADDR_W-1:2] == idx);
	endfunction : reg_hit

endpackage : radio_irq_pkg

/* File: hw/radio_rise_detect.sv */
// Turns a vector of status levels into one-cycle pulses on each 0 to 1 step.
module radio_rise_detect #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] level_i,
	output logic [WIDTH-1:0] rise_o
);

	// Level seen in the previous enabled cycle.
	logic [WIDTH-1:0] prev_q;

	// A bit rises only when it is high now and was low before.
	assign rise_o = level_i & ~prev_q;

	// The history only moves while the clock enable is high.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prev_q <= '0;
		end else if (ce_i) begin
			prev_q <= level_i;
		end
	end

endmodule : radio_rise_detect

/* File: hw/radio_interrupt_flags.sv */
// Radio interrupt flags, mask and the two CPU interrupt requests.
//
// Decided for this implementation: the Avalon-MM register port.
module radio_interrupt_flags (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [radio_irq_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [7:0] radio_status_i,
	input wire logic rx_byte_arrived_i,
	input wire logic rx_byte_read_i,
	input wire logic tx_byte_room_i,
	input wire logic tx_short_i,
	input wire logic status1_read_i,
	input wire logic strobe_valid_i,
	input wire logic [7:0] strobe_code_i,
	output logic byte_transfer_irq_o,
	output logic general_radio_irq_o
);

	// Bus handshake state: high while a new request still waits.
	logic wait_q;
	logic [31:0] readdata_q;

	// Software visible registers.
	logic [7:0] mask_q;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic bt_flag_q;
	logic bt_flag_d;
	logic gr_flag_q;
	logic gr_flag_d;
	logic bt_en_q;
	logic gr_en_q;
	logic append_q;

	// Radio data path state and fault kinds.
	radio_irq_pkg::radio_state_t state_q;
	radio_irq_pkg::radio_state_t state_d;
	logic overrun_q;
	logic short_q;
	logic pending_q;

	// Registered request outputs.
	logic bt_irq_q;
	logic gr_irq_q;

	// Decoded bus accesses.
	wire req = avs_read_i | avs_write_i;
	wire hit_mask = radio_irq_pkg::reg_hit(avs_address_i, radio_irq_pkg::MASK_IDX);
	wire hit_flags = radio_irq_pkg::reg_hit(avs_address_i, radio_irq_pkg::FLAGS_IDX);
	wire hit_ctrl = radio_irq_pkg::reg_hit(avs_address_i, radio_irq_pkg::CTRL_IDX);
	wire wr_go = ce_i & avs_write_i & ~wait_q & avs_byteenable_i[0];
	wire mask_wr = wr_go & hit_mask;
	wire flags_wr = wr_go & hit_flags;
	wire ctrl_wr = wr_go & hit_ctrl;
	wire [7:0] wbyte = avs_writedata_i[7:0];

	// Decoded command strobes.
	wire tx_strobe = strobe_valid_i & (strobe_code_i == radio_irq_pkg::TX_STROBE_CODE);
	wire idle_strobe = strobe_valid_i & (strobe_code_i == radio_irq_pkg::IDLE_STROBE_CODE);

	// An unread byte overwritten while receiving is an overrun.
	wire in_tx = (state_q == radio_irq_pkg::ST_TX);
	wire overrun_evt = rx_byte_arrived_i & pending_q & ~rx_byte_read_i & ~in_tx;
	// Missing transmit data counts only while transmitting.
	wire short_evt = tx_short_i & in_tx;

	// Fault states feed the edge detector like any radio status level.
	logic [7:0] fault_bits;
	always_comb begin
		fault_bits = 8'h00;
		fault_bits[radio_irq_pkg::TX_SHORT_BIT] = short_q;
		fault_bits[radio_irq_pkg::RX_OVERRUN_BIT] = overrun_q;
		fault_bits[radio_irq_pkg::PACKET_FINISHED_BIT] = overrun_q | short_q;
	end

	// Status levels in their flag positions, ORed with the fault states.
	wire [7:0] cond = radio_status_i | fault_bits;
	wire [7:0] rise;

	// Events fire on the 0 to 1 step of their condition only.
	radio_rise_detect #(
		.WIDTH(8)
	) u_rise (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.level_i(cond),
		.rise_o(rise)
	);

	// Writing 0 clears a flag, 1 keeps it, and a new event wins.
	wire [7:0] flags_clr = flags_wr ? ~wbyte : 8'h00;
	assign flags_d = (flags_q & ~flags_clr) | rise;

	// Any masked-in event raises the general CPU flag.
	wire gr_set = |(rise & mask_q);
	wire gr_clr = ctrl_wr & ~wbyte[radio_irq_pkg::CTRL_GR_FLAG];
	assign gr_flag_d = gr_set | (gr_flag_q & ~gr_clr);

	// Byte flag: received byte, free register in transmit, or status byte 1.
	wire bt_rx = rx_byte_arrived_i;
	wire bt_tx = tx_byte_room_i & in_tx;
	wire bt_status = status1_read_i & append_q;
	wire bt_set = bt_rx | bt_tx | bt_status;
	wire bt_clr = ctrl_wr & ~wbyte[radio_irq_pkg::CTRL_BT_FLAG];
	assign bt_flag_d = bt_set | (bt_flag_q & ~bt_clr);

	// Control register view with live state in its upper bits.
	logic [7:0] ctrl_view;
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[radio_irq_pkg::CTRL_BT_FLAG] = bt_flag_q;
		ctrl_view[radio_irq_pkg::CTRL_GR_FLAG] = gr_flag_q;
		ctrl_view[radio_irq_pkg::CTRL_BT_EN] = bt_en_q;
		ctrl_view[radio_irq_pkg::CTRL_GR_EN] = gr_en_q;
		ctrl_view[radio_irq_pkg::CTRL_APPEND] = append_q;
		ctrl_view[radio_irq_pkg::CTRL_OVERRUN] = overrun_q;
		ctrl_view[radio_irq_pkg::CTRL_SHORT] = short_q;
		ctrl_view[radio_irq_pkg::CTRL_TX] = in_tx;
	end

	// Read data selection; unmapped addresses read as zero.
	wire [31:0] rd_mux = hit_mask ? {24'h00_0000, mask_q} :
		hit_flags ? {24'h00_0000, flags_q} :
		hit_ctrl ? {24'h00_0000, ctrl_view} : 32'h0000_0000;

	// Next state: the idle strobe always wins and clears any fault.
	always_comb begin
		state_d = state_q;
		case (state_q)
			radio_irq_pkg::ST_IDLE: begin
				if (idle_strobe) begin
					state_d = radio_irq_pkg::ST_IDLE;
				end else if (overrun_evt) begin
					state_d = radio_irq_pkg::ST_STUCK;
				end else if (tx_strobe) begin
					state_d = radio_irq_pkg::ST_TX;
				end
			end
			radio_irq_pkg::ST_TX: begin
				if (idle_strobe) begin
					state_d = radio_irq_pkg::ST_IDLE;
				end else if (short_evt) begin
					state_d = radio_irq_pkg::ST_STUCK;
				end
			end
			radio_irq_pkg::ST_STUCK: begin
				if (idle_strobe) begin
					state_d = radio_irq_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = radio_irq_pkg::ST_IDLE;
			end
		endcase
	end

	// Bus slave: one wait cycle, then the access completes.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wait_q <= 1'b1;
			readdata_q <= radio_irq_pkg::READ_RST;
		end else if (ce_i) begin
			wait_q <= ~(req & wait_q);
			if (avs_read_i & wait_q) begin
				readdata_q <= rd_mux;
			end
		end
	end

	// Mask and control bits written by software.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mask_q <= radio_irq_pkg::MASK_RST;
			bt_en_q <= 1'b0;
			gr_en_q <= 1'b0;
			append_q <= 1'b0;
		end else if (mask_wr) begin
			mask_q <= wbyte;
		end else if (ctrl_wr) begin
			bt_en_q <= wbyte[radio_irq_pkg::CTRL_BT_EN];
			gr_en_q <= wbyte[radio_irq_pkg::CTRL_GR_EN];
			append_q <= wbyte[radio_irq_pkg::CTRL_APPEND];
		end
	end

	// Sticky flags of both levels.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			flags_q <= radio_irq_pkg::FLAGS_RST;
			bt_flag_q <= 1'b0;
			gr_flag_q <= 1'b0;
		end else if (ce_i) begin
			flags_q <= flags_d;
			bt_flag_q <= bt_flag_d;
			gr_flag_q <= gr_flag_d;
		end
	end

	// Data path state, fault kinds and the unread byte marker.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q <= radio_irq_pkg::ST_IDLE;
			overrun_q <= 1'b0;
			short_q <= 1'b0;
			pending_q <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			overrun_q <= ~idle_strobe & (overrun_q | overrun_evt);
			short_q <= ~idle_strobe & (short_q | short_evt);
			pending_q <= ~idle_strobe & (bt_rx | (pending_q & ~rx_byte_read_i));
		end
	end

	// Requests follow the CPU flags gated by their enables, one cycle later.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bt_irq_q <= 1'b0;
			gr_irq_q <= 1'b0;
		end else if (ce_i) begin
			bt_irq_q <= bt_flag_q & bt_en_q;
			gr_irq_q <= gr_flag_q & gr_en_q;
		end
	end

	// Outputs straight from flip-flops.
	assign avs_waitrequest_o = wait_q;
	assign avs_readdata_o = readdata_q;
	assign byte_transfer_irq_o = bt_irq_q;
	assign general_radio_irq_o = gr_irq_q;

	// Checks on the flag and request behaviour.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	// A rising condition leaves its flag set after the edge.
	property p_rise_sets;
		ce_i && (rise != 8'h00) |=> ((flags_q & $past(rise)) == $past(rise));
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("event flag not set");

	// A flag never turns on without a rise in the cycle before.
	property p_no_level_set;
		ce_i |=> ((flags_q & ~$past(flags_q) & ~$past(rise)) == 8'h00);
	endproperty
	a_no_level_set: assert property (p_no_level_set) else $error("flag set without edge");

	// Written zeros clear flags unless an event arrives in the same cycle.
	property p_write_clear;
		flags_wr |=> ((flags_q & ~$past(wbyte) & ~$past(rise)) == 8'h00);
	endproperty
	a_write_clear: assert property (p_write_clear) else $error("flag clear failed");

	// The byte request mirrors flag and enable one cycle late.
	property p_bt_request;
		ce_i |=> (byte_transfer_irq_o == $past(bt_flag_q & bt_en_q));
	endproperty
	a_bt_request: assert property (p_bt_request) else $error("byte request wrong");

	// The general request mirrors its flag and enable one cycle late.
	property p_gr_request;
		ce_i |=> (general_radio_irq_o == $past(gr_flag_q & gr_en_q));
	endproperty
	a_gr_request: assert property (p_gr_request) else $error("general request wrong");

	// A masked-in event sets the general flag at the next edge.
	property p_gr_set;
		ce_i && ((rise & mask_q) != 8'h00) |=> gr_flag_q;
	endproperty
	a_gr_set: assert property (p_gr_set) else $error("general flag missed");

	// Events masked out leave a cleared general flag alone.
	property p_masked_out;
		ce_i && !gr_flag_q && ((rise & mask_q) == 8'h00) |=> !gr_flag_q;
	endproperty
	a_masked_out: assert property (p_masked_out) else $error("masked event leaked");

	// Outside transmit, a free register alone never raises the byte flag.
	property p_tx_gate;
		ce_i && !in_tx && !bt_rx && !bt_status && !bt_flag_q |=> !bt_flag_q;
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("byte flag before transmit");

	// Reading status byte 1 with appending on raises the byte flag.
	property p_status_flag;
		ce_i && status1_read_i && append_q |=> bt_flag_q;
	endproperty
	a_status_flag: assert property (p_status_flag) else $error("status byte flag missed");

	// An overrun enters the fault state, then both flags follow.
	// The fault state must be new, so a repeated overrun while stuck raises no edge.
	sequence s_overrun_enter;
		ce_i && overrun_evt && !idle_strobe ##1 ($rose(overrun_q) && ce_i);
	endsequence
	property p_overrun_flags;
		s_overrun_enter |=> (flags_q[radio_irq_pkg::RX_OVERRUN_BIT] &&
			flags_q[radio_irq_pkg::PACKET_FINISHED_BIT]);
	endproperty
	a_overrun_flags: assert property (p_overrun_flags) else $error("overrun flags missing");

	// A short transmit enters the fault state, then both flags follow.
	sequence s_short_enter;
		ce_i && short_evt && !idle_strobe ##1 (short_q && ce_i);
	endsequence
	property p_short_flags;
		s_short_enter |=> (flags_q[radio_irq_pkg::TX_SHORT_BIT] &&
			flags_q[radio_irq_pkg::PACKET_FINISHED_BIT]);
	endproperty
	a_short_flags: assert property (p_short_flags) else $error("underflow flags missing");

	// A fault state holds until the idle strobe.
	property p_fault_holds;
		(overrun_q || short_q) && !(ce_i && idle_strobe) |=> (overrun_q || short_q);
	endproperty
	a_fault_holds: assert property (p_fault_holds) else $error("fault left early");

endmodule : radio_interrupt_flags

/* File: tb/radio_side_model.sv */
// Radio side of the block: status levels and one-cycle event pulses.
module radio_side_model (
	input wire logic clk_i,
	output logic [7:0] status_o,
	output logic arrived_o,
	output logic read_o,
	output logic room_o,
	output logic short_o,
	output logic s1_o,
	output logic stb_valid_o,
	output logic [7:0] stb_code_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// All lines start quiet so the block sees no event after reset.
	initial begin
		status_o = 8'h00;
		{arrived_o, read_o, room_o, short_o, s1_o, stb_valid_o} = 6'h00;
		stb_code_o = 8'h00;
	end

	// Moves the status levels at a clock edge; a level held high is one event only.
	task automatic lvl(input logic [7:0] v);
		@(posedge clk_i);
		status_o <= v;
	endtask : lvl

	// Raises one event line for exactly one cycle: 0 arrived, 1 read, 2 room, 3 short,
	// 4 status byte one read, 5 command strobe with the given code.
	task automatic pulse(input int k, input logic [7:0] code);
		@(posedge clk_i);
		case (k)
			0: arrived_o <= 1'b1;
			1: read_o <= 1'b1;
			2: room_o <= 1'b1;
			3: short_o <= 1'b1;
			4: s1_o <= 1'b1;
			default: begin
				stb_valid_o <= 1'b1;
				stb_code_o <= code;
			end
		endcase
		@(posedge clk_i);
		{arrived_o, read_o, room_o, short_o, s1_o, stb_valid_o} <= 6'h00;
		stb_code_o <= ~code;
	endtask : pulse
endmodule : radio_side_model

/* File: tb/radio_interrupt_flags_tb_top.sv */
// Self-checking bench: Avalon master, radio model and a read-data monitor.
module radio_interrupt_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [9:0] A_M = {radio_irq_pkg::MASK_IDX, 2'b00};
	localparam logic [9:0] A_F = {radio_irq_pkg::FLAGS_IDX, 2'b00};
	localparam logic [9:0] A_C = {radio_irq_pkg::CTRL_IDX, 2'b00};
	logic clk_i, rstn_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [9:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0] avs_byteenable_i;
	logic [7:0] status, code;
	logic arr, rdp, room, shrt, s1, stv, bt_irq, gr_irq;
	logic [31:0] exp_q[$]; // Expected read data, oldest first.
	int n_errors = 0;
	int n_compared = 0;
	logic [7:0] v;

	radio_side_model rm (.clk_i(clk_i), .status_o(status), .arrived_o(arr), .read_o(rdp),
		.room_o(room), .short_o(shrt), .s1_o(s1), .stb_valid_o(stv), .stb_code_o(code));

	radio_interrupt_flags dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.radio_status_i(status), .rx_byte_arrived_i(arr), .rx_byte_read_i(rdp),
		.tx_byte_room_i(room), .tx_short_i(shrt), .status1_read_i(s1), .strobe_valid_i(stv),
		.strobe_code_i(code), .byte_transfer_irq_o(bt_irq), .general_radio_irq_o(gr_irq));

	// The 8 ns clock.
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Compares one value and counts it.
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop

	// One Avalon access held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int t;
		t = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h000000, d};
		avs_byteenable_i <= be;
		if (wr) avs_write_i <= 1'b1;
		else avs_read_i <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
		end while (avs_waitrequest_o !== 1'b0 && t < 50);
		if (t >= 50) n_errors++;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr

	// Notes the expected word, then reads; the monitor compares.
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(1'b0, a, 8'h00, 4'hF);
	endtask : rd

	// Takes the oldest note whenever read data is handed over.
	always @(posedge clk_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
			if (exp_q.size() == 0) check("unexpected read", avs_readdata_o, 32'hFFFFFFFF);
			else check("readdata", avs_readdata_o, exp_q.pop_front());
		end
	end

	// Cuts a hang short well past the expected run length.
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		{rstn_i, avs_read_i, avs_write_i} = 3'b000;
		ce_i = 1'b1;
		avs_address_i = 10'h000;
		avs_writedata_i = 32'h00000000;
		avs_byteenable_i = 4'hF;
		void'($urandom(37025));
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		// Reset values, an unmapped place, and a random mask round trip.
		rd(A_M, 8'h00);
		rd(A_F, 8'h00);
		rd(10'h004, 8'h00);
		v = 8'($urandom());
		wr(A_M, v);
		rd(A_M, v);
		bus(1'b1, A_M, ~v, 4'h0);
		rd(A_M, v);
		// A masked-out event sets its flag but no general request.
		wr(A_M, 8'h00);
		wr(A_C, 8'h08);
		rm.lvl(8'h20);
		rd(A_F, 8'h20);
		check("gr_irq", 32'(gr_irq), 32'h0);
		wr(A_F, 8'h00);
		rm.lvl(8'h00);
		// Each event bit alone: position, general flag and request, sticky level.
		for (int i = 0; i < 8; i++) begin
			wr(A_M, 8'h01 << i);
			rm.lvl(8'h01 << i);
			repeat (3) @(posedge clk_i);
			wr(A_F, 8'hFF);
			rd(A_F, 8'h01 << i);
			check("gr_irq", 32'(gr_irq), 32'h1);
			wr(A_F, 8'h00);
			wr(A_C, 8'h08);
			rd(A_F, 8'h00);
			check("gr_irq", 32'(gr_irq), 32'h0);
			rm.lvl(8'h00);
		end
		// Received byte with the request enabled, then disabled.
		wr(A_C, 8'h04);
		rm.pulse(0, 8'h00);
		rd(A_C, 8'h05);
		check("bt_irq", 32'(bt_irq), 32'h1);
		wr(A_C, 8'h04);
		rm.pulse(1, 8'h00);
		wr(A_C, 8'h00);
		rm.pulse(0, 8'h00);
		rd(A_C, 8'h01);
		check("bt_irq", 32'(bt_irq), 32'h0);
		wr(A_C, 8'h04);
		rm.pulse(1, 8'h00);
		// Transmit room is ignored before the transmit strobe.
		rm.pulse(2, 8'h00);
		rd(A_C, 8'h04);
		rm.pulse(5, radio_irq_pkg::TX_STROBE_CODE);
		rm.pulse(2, 8'h00);
		rd(A_C, 8'h85);
		wr(A_C, 8'h04);
		// Underflow in transmit, then the idle strobe.
		rm.pulse(3, 8'h00);
		rd(A_F, 8'h90);
		// Stuck is not transmit; the masked-in underflow also set the general flag.
		rd(A_C, 8'h46);
		rm.pulse(5, radio_irq_pkg::IDLE_STROBE_CODE);
		rd(A_C, 8'h06);
		wr(A_F, 8'h00);
		// Unread byte overwritten.
		rm.pulse(0, 8'h00);
		rm.pulse(0, 8'h00);
		rd(A_F, 8'h50);
		rd(A_C, 8'h27);
		rm.pulse(5, radio_irq_pkg::IDLE_STROBE_CODE);
		wr(A_F, 8'h00);
		// Status byte one read raises the byte flag only with appending on.
		wr(A_C, 8'h14);
		rm.pulse(4, 8'h00);
		rd(A_C, 8'h15);
		wr(A_C, 8'h04);
		rm.pulse(4, 8'h00);
		rd(A_C, 8'h04);
		// With the clock enable low a received byte is not seen at all.
		@(posedge clk_i);
		ce_i <= 1'b0;
		rm.pulse(0, 8'h00);
		ce_i <= 1'b1;
		rd(A_C, 8'h04);
		repeat (2) @(posedge clk_i);
		report_and_stop();
	end
endmodule : radio_interrupt_flags_tb_top
